// ==== core/ehw_pkg.sv ====
package ehw_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int LEAD_W = 2;
    localparam int ACT_W = 3;
    localparam int TRAIL_W = 2;
    localparam int CNT_DEF = 5;
    localparam int ASYNC_EARLY = 2;
    localparam int TIM_SYNC_W = 22;
    localparam logic [1:0] ZONE_A = 2'h0;
    localparam logic [1:0] ZONE_B = 2'h1;
    localparam logic [1:0] ZONE_C = 2'h2;
    localparam logic HOLD_MODE_RST = 1'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [2:0] {
        T_IDLE, T_ALIGN, T_LEAD, T_ACTIVE, T_TRAIL, T_FLOAT, T_GRANTED, T_RELEASE
    } ehw_tst_t;

    typedef enum logic {C_IDLE, C_WAIT} ehw_cst_t;

    // phase length in timing-clock cycles, doubled when timing doubling is selected
    function automatic logic [CNT_DEF-1:0] ehw_scale(input logic [ACT_W-1:0] v, input logic x2);
        logic [CNT_DEF-1:0] r;
        r = {{(CNT_DEF-ACT_W){1'b0}}, v};
        return x2 ? {r[CNT_DEF-2:0], 1'b0} : r;
    endfunction
endpackage

// ==== core/ehw_sync.sv ====
`timescale 1ns/100ps
// plain two-stage synchroniser; first stage feeds nothing but the second
module ehw_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        q_o <= meta_q;
    end
endmodule // ehw_sync

// ==== core/ehw_bus_clk.sv ====
`timescale 1ns/100ps
module ehw_bus_clk
    import ehw_pkg::*;
(
    input wire logic tim_clk_i,
    input wire logic rst_i,
    input wire logic half_i,
    output logic bclk_o,
    output logic aligned_o
);
    logic bclk_q;

    // full rate: the timing clock itself is the bus clock at the pad, so the level is parked high
    always_ff @(posedge tim_clk_i) begin
        if (rst_i || !half_i) begin
            bclk_q <= 1'h1;
        end else begin
            bclk_q <= !bclk_q;
        end
    end

    assign bclk_o = bclk_q;
    // true when the coming edge is a rising edge of the bus clock
    assign aligned_o = !half_i || !bclk_q;
endmodule // ehw_bus_clk

// ==== core/ehw_core.sv ====
`timescale 1ns/100ps
// Overview of operation
// - every access lead starts on a bus clock rising edge; align cycle inserted if needed
// - alignment cycles keep all strobes and selects inactive
// - between accesses the address bus holds the last address
// - synchronous ready: first write sample at lead plus active cycles
// - asynchronous ready: first write sample two cycles earlier
// - ready high completes the access, low resamples every timing cycle
// - hold mode set during a grant forces acknowledge high and drives the bus
// - system reset clears the hold mode bit
// - with holding allowed, internal execution continues while the bus is granted
// - external accesses stall while the bus is granted away
// - a grant floats address, data, strobes, direction and the three zone selects
// - other signals, such as the bus clock, keep working during a grant
// - a pending external access finishes before the bus floats
// - bus request is registered on the timing clock
// - full rate: float within 4, acknowledge low within 5 timing cycles
// - full rate: acknowledge high within 3, bus valid within 4 timing cycles
// - half rate: float 4t+1 bus clock, ack low 4t+2, ack high 4t, valid 6t
// - after a sampled request change, bus and acknowledge move on bus clock rising edges
module ehw_core
    import ehw_pkg::*;
#(
    parameter int unsigned CNT_W = CNT_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    input wire logic [1:0] req_zone_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    input wire logic [LEAD_W-1:0] write_lead_cycles_i,
    input wire logic [ACT_W-1:0] write_active_cycles_i,
    input wire logic [TRAIL_W-1:0] write_trail_cycles_i,
    input wire logic ready_sampling_enable_i,
    input wire logic ready_async_select_i,
    input wire logic timing_doubling_select_i,
    input wire logic bus_clock_half_i,
    input wire logic hold_mode_wr_i,
    input wire logic hold_mode_wdata_i,
    output logic hold_mode_o,
    output logic hold_granted_o,
    input wire logic interface_timing_clock_i,
    output logic bus_clock_output_o,
    input wire logic bus_request_n_i,
    output logic bus_grant_ack_n_o,
    input wire logic external_ready_in_i,
    output logic [ADDR_W-1:0] ext_address_bus_o,
    output logic ext_address_bus_oe_o,
    output logic [DATA_W-1:0] ext_data_bus_o,
    output logic ext_data_bus_oe_o,
    input wire logic [DATA_W-1:0] ext_data_bus_i,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    output logic read_write_direction_o,
    output logic zone_select_a_n_o,
    output logic zone_select_b_n_o,
    output logic zone_select_c_n_o,
    output logic control_oe_o
);
    if (CNT_W != CNT_DEF) begin : g_chk
        $error("ehw_core: CNT_W must match the package phase width");
    end

    typedef struct packed {
        ehw_cst_t st;
        logic req_tgl;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic [1:0] zone;
        logic [ACT_W-1:0] lead;
        logic [ACT_W-1:0] act;
        logic [ACT_W-1:0] trail;
        logic use_rdy;
        logic async;
        logic x2;
        logic req_ready;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic hold_mode;
        logic granted;
    } ehw_cpu_t;

    typedef struct packed {
        ehw_tst_t st;
        logic [CNT_W-1:0] pc;
        logic ok;
        logic seen_tgl;
        logic ack_tgl;
        logic [1:0] cap;
        logic [ADDR_W-1:0] addr;
        logic addr_oe;
        logic [DATA_W-1:0] dout;
        logic dout_oe;
        logic we_n;
        logic rd_n;
        logic rw;
        logic cs_a_n;
        logic cs_b_n;
        logic cs_c_n;
        logic ctl_oe;
        logic ack_n;
        logic [DATA_W-1:0] rdata;
    } ehw_tim_t;

    ehw_cpu_t c_q, c_d;
    ehw_tim_t t_q, t_d;

    // link side and processor side synchronised inputs, bus clock signals
    logic [TIM_SYNC_W-1:0] tsync;
    logic rst_s, req_tgl_s, hold_s, half_s, req_n_s, rdy_s;
    logic [DATA_W-1:0] din_s;
    logic [1:0] csync;
    logic ack_tgl_s, granted_s;
    logic bclk, aligned;

    ehw_sync #(.W(TIM_SYNC_W)) u_tsync (
        .clk_i(interface_timing_clock_i),
        .d_i({rst_i, c_q.req_tgl, c_q.hold_mode, bus_clock_half_i, bus_request_n_i,
              external_ready_in_i, ext_data_bus_i}),
        .q_o(tsync)
    );
    assign {rst_s, req_tgl_s, hold_s, half_s, req_n_s, rdy_s, din_s} = tsync;

    ehw_sync #(.W(2)) u_csync (
        .clk_i(clk_i),
        .d_i({t_q.ack_tgl, !t_q.ack_n}),
        .q_o(csync)
    );
    assign {ack_tgl_s, granted_s} = csync;

    // bus clock keeps running through a grant
    ehw_bus_clk u_bclk (
        .tim_clk_i(interface_timing_clock_i),
        .rst_i(rst_s),
        .half_i(half_s),
        .bclk_o(bclk),
        .aligned_o(aligned)
    );

    // processor side
    always_comb begin
        c_d = c_q;
        c_d.rsp_valid = 1'h0;
        c_d.granted = granted_s;
        if (hold_mode_wr_i) begin
            c_d.hold_mode = hold_mode_wdata_i;
        end
        case (c_q.st)
            // only external requests wait here; internal execution never passes through this block
            C_IDLE: begin
                if (req_valid_i && c_q.req_ready) begin
                    c_d.st = C_WAIT;
                    c_d.req_tgl = !c_q.req_tgl;
                    c_d.req_ready = 1'h0;
                    c_d.addr = req_addr_i;
                    c_d.wdata = req_wdata_i;
                    c_d.wr = req_write_i;
                    c_d.zone = req_zone_i;
                    c_d.lead = {1'b0, write_lead_cycles_i};
                    c_d.act = write_active_cycles_i;
                    c_d.trail = {1'b0, write_trail_cycles_i};
                    c_d.use_rdy = ready_sampling_enable_i;
                    c_d.async = ready_async_select_i;
                    c_d.x2 = timing_doubling_select_i;
                end
            end
            C_WAIT: begin
                if (ack_tgl_s == c_q.req_tgl) begin
                    c_d.st = C_IDLE;
                    c_d.rsp_valid = 1'h1;
                    c_d.rdata = t_q.rdata;
                    c_d.req_ready = 1'h1;
                end
            end
            default: c_d.st = C_IDLE;
        endcase
        if (rst_i) begin
            c_d = '0;
            c_d.st = C_IDLE;
            c_d.req_ready = 1'h1;
            c_d.hold_mode = HOLD_MODE_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        c_q <= c_d;
    end

    // link side
    logic pend;
    logic [CNT_W-1:0] len_l, len_a, len_t, samp_at;
    logic samp_now, act_done;

    always_comb begin
        t_d = t_q;
        // read word reaches the synchronised bus two edges after the strobe rises
        t_d.cap = {t_q.cap[0], 1'h0};
        if (t_q.cap[1]) begin
            t_d.rdata = din_s;
        end
        // answer only once no access runs and no read word is still in flight
        if (t_q.cap == '0 && t_q.st inside {T_IDLE, T_FLOAT, T_GRANTED, T_RELEASE}) begin
            t_d.ack_tgl = t_q.seen_tgl;
        end
        pend = (req_tgl_s != t_q.seen_tgl);
        len_l = ehw_scale(c_q.lead, c_q.x2);
        len_a = ehw_scale(c_q.act, c_q.x2);
        if (len_a == '0) begin
            len_a = CNT_W'(1);
        end
        len_t = ehw_scale(c_q.trail, c_q.x2);
        if (len_l == '0) begin
            len_l = CNT_W'(1);
        end
        // first sample index within the active phase
        samp_at = len_a - CNT_W'(1);
        if (c_q.async) begin
            samp_at = (len_a > CNT_W'(ASYNC_EARLY)) ? len_a - CNT_W'(ASYNC_EARLY + 1) : '0;
        end
        samp_now = c_q.use_rdy && (t_q.pc >= samp_at) && rdy_s;
        act_done = (t_q.pc >= len_a - CNT_W'(1)) && (!c_q.use_rdy || t_q.ok || samp_now);
        case (t_q.st)
            T_IDLE: begin
                if (pend) begin
                    t_d.seen_tgl = req_tgl_s;
                    t_d.st = T_ALIGN;
                    if (aligned) begin
                        t_d.st = T_LEAD;
                        t_d.pc = '0;
                        t_d.ok = 1'h0;
                        t_d.addr = c_q.addr;
                        t_d.rw = !c_q.wr;
                        t_d.cs_a_n = (c_q.zone != ZONE_A);
                        t_d.cs_b_n = (c_q.zone != ZONE_B);
                        t_d.cs_c_n = (c_q.zone != ZONE_C);
                    end
                end else if (!req_n_s && !hold_s && aligned) begin
                    t_d.st = T_FLOAT;
                    t_d.addr_oe = 1'h0;
                    t_d.ctl_oe = 1'h0;
                    t_d.dout_oe = 1'h0;
                end
            end
            // strobes and selects already inactive from the last trail
            T_ALIGN: begin
                if (aligned) begin
                    t_d.st = T_LEAD;
                    t_d.pc = '0;
                    t_d.ok = 1'h0;
                    t_d.addr = c_q.addr;
                    t_d.rw = !c_q.wr;
                    t_d.cs_a_n = (c_q.zone != ZONE_A);
                    t_d.cs_b_n = (c_q.zone != ZONE_B);
                    t_d.cs_c_n = (c_q.zone != ZONE_C);
                end
            end
            T_LEAD: begin
                t_d.pc = t_q.pc + CNT_W'(1);
                if (t_q.pc >= len_l - CNT_W'(1)) begin
                    t_d.st = T_ACTIVE;
                    t_d.pc = '0;
                    t_d.we_n = !c_q.wr;
                    t_d.rd_n = c_q.wr;
                    t_d.dout = c_q.wdata;
                    t_d.dout_oe = c_q.wr;
                end
            end
            T_ACTIVE: begin
                // counter saturates while ready keeps the access waiting
                if (t_q.pc != '1) begin
                    t_d.pc = t_q.pc + CNT_W'(1);
                end
                if (samp_now) begin
                    t_d.ok = 1'h1;
                end
                if (act_done) begin
                    t_d.we_n = 1'h1;
                    t_d.rd_n = 1'h1;
                    t_d.pc = '0;
                    t_d.cap[0] = !c_q.wr;
                    t_d.st = T_TRAIL;
                    if (len_t == '0) begin
                        t_d.st = T_IDLE;
                        t_d.cs_a_n = 1'h1;
                        t_d.cs_b_n = 1'h1;
                        t_d.cs_c_n = 1'h1;
                        t_d.rw = 1'h1;
                        t_d.dout_oe = 1'h0;
                    end
                end
            end
            T_TRAIL: begin
                t_d.pc = t_q.pc + CNT_W'(1);
                if (t_q.pc >= len_t - CNT_W'(1)) begin
                    // address left as is so the bus holds it between accesses
                    t_d.st = T_IDLE;
                    t_d.cs_a_n = 1'h1;
                    t_d.cs_b_n = 1'h1;
                    t_d.cs_c_n = 1'h1;
                    t_d.rw = 1'h1;
                    t_d.dout_oe = 1'h0;
                end
            end
            T_FLOAT: begin
                if (hold_s || req_n_s) begin
                    t_d.st = T_RELEASE;
                end else if (aligned) begin
                    t_d.st = T_GRANTED;
                    t_d.ack_n = 1'h0;
                end
            end
            // pending requests are not served in this state
            T_GRANTED: begin
                if (hold_s) begin
                    t_d.st = T_IDLE;
                    t_d.ack_n = 1'h1;
                    t_d.addr_oe = 1'h1;
                    t_d.ctl_oe = 1'h1;
                end else if (req_n_s && aligned) begin
                    t_d.st = T_RELEASE;
                    t_d.ack_n = 1'h1;
                end
            end
            T_RELEASE: begin
                if (aligned) begin
                    t_d.st = T_IDLE;
                    t_d.addr_oe = 1'h1;
                    t_d.ctl_oe = 1'h1;
                end
            end
            default: t_d.st = T_IDLE;
        endcase
        if (rst_s) begin
            t_d = '0;
            t_d.addr = ADDR_RST;
            t_d.dout = DATA_RST;
            t_d.rdata = DATA_RST;
            t_d.we_n = 1'h1;
            t_d.rd_n = 1'h1;
            t_d.rw = 1'h1;
            t_d.cs_a_n = 1'h1;
            t_d.cs_b_n = 1'h1;
            t_d.cs_c_n = 1'h1;
            // bus floated for all of reset; acknowledge follows the request
            t_d.ack_n = req_n_s;
            t_d.st = req_n_s ? T_RELEASE : T_GRANTED;
        end
    end

    always_ff @(posedge interface_timing_clock_i) begin
        t_q <= t_d;
    end

    assign req_ready_o = c_q.req_ready;
    assign rsp_valid_o = c_q.rsp_valid;
    assign rsp_rdata_o = c_q.rdata;
    assign hold_mode_o = c_q.hold_mode;
    assign hold_granted_o = c_q.granted;
    assign bus_clock_output_o = bclk;
    assign bus_grant_ack_n_o = t_q.ack_n;
    assign ext_address_bus_o = t_q.addr;
    assign ext_address_bus_oe_o = t_q.addr_oe;
    assign ext_data_bus_o = t_q.dout;
    assign ext_data_bus_oe_o = t_q.dout_oe;
    assign write_strobe_n_o = t_q.we_n;
    assign read_strobe_n_o = t_q.rd_n;
    assign read_write_direction_o = t_q.rw;
    assign zone_select_a_n_o = t_q.cs_a_n;
    assign zone_select_b_n_o = t_q.cs_b_n;
    assign zone_select_c_n_o = t_q.cs_c_n;
    assign control_oe_o = t_q.ctl_oe;

    property p_align_idle;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_ALIGN) |-> (t_q.we_n && t_q.rd_n && t_q.cs_a_n && t_q.cs_b_n && t_q.cs_c_n);
    endproperty
    a_align_idle: assert property (p_align_idle) else $error("strobe active in align cycle");

    property p_lead_aligned;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_LEAD && $past(t_q.st) != T_LEAD) |-> $past(aligned);
    endproperty
    a_lead_aligned: assert property (p_lead_aligned) else $error("lead began off a rising edge");

    property p_addr_hold;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_ALIGN) |-> $stable(t_q.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved while inactive");

    property p_sync_early;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_ACTIVE && c_q.use_rdy && !c_q.async && t_q.pc < len_a - CNT_W'(1)) |=> (t_q.st == T_ACTIVE);
    endproperty
    a_sync_early: assert property (p_sync_early) else $error("write ended before first sample");

    property p_async_sample;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_ACTIVE && c_q.use_rdy && c_q.async && t_q.pc == samp_at && rdy_s) |=> t_q.ok;
    endproperty
    a_async_sample: assert property (p_async_sample) else $error("early ready sample missed");

    property p_ready_wait;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_ACTIVE && c_q.use_rdy && !t_q.ok && !rdy_s) |=> (t_q.st == T_ACTIVE);
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("access left active with ready low");

    property p_grant_float;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_GRANTED) |-> (!t_q.addr_oe && !t_q.dout_oe && !t_q.ctl_oe);
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("bus driven during grant");

    property p_grant_time;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        ($fell(req_n_s) && t_q.st == T_IDLE && !pend && !hold_s && !half_s) |=> !t_q.ctl_oe ##1 !t_q.ack_n;
    endproperty
    a_grant_time: assert property (p_grant_time) else $error("grant too slow at full rate");

    property p_release_time;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        ($rose(req_n_s) && t_q.st == T_GRANTED && !hold_s && !half_s) |=> t_q.ack_n ##1 t_q.ctl_oe;
    endproperty
    a_release_time: assert property (p_release_time) else $error("release too slow at full rate");

    property p_hold_mode_release;
        @(posedge interface_timing_clock_i) disable iff (rst_s)
        (t_q.st == T_GRANTED && hold_s) |=> (t_q.ack_n && t_q.ctl_oe && t_q.addr_oe);
    endproperty
    a_hold_mode_release: assert property (p_hold_mode_release) else $error("hold mode did not end grant");
endmodule // ehw_core

// ==== testbench/ehw_mem_model.sv ====
`timescale 1ns/100ps
module ehw_mem_model
    import ehw_pkg::*;
(
    input wire logic tim_clk_i,
    input wire logic hold_req_i,
    input wire logic [1:0] stall_i,
    input wire logic sel_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic bus_request_n_o,
    output logic ready_o,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [16] = '{default: 16'h0000};
    logic [2:0] cnt = 3'h0;
    logic [1:0] keep = 2'h0;
    logic [3:0] a_q = 4'h0;
    logic req_n_q = 1'b1;
    logic rdy_q = 1'b0;
    logic [DATA_W-1:0] rd_q = 16'h0000;

    assign bus_request_n_o = req_n_q;
    assign ready_o = rdy_q;
    assign rdata_o = rd_q;
    // falling edge only, away from the device's sampling edge
    always @(negedge tim_clk_i) begin
        req_n_q <= ~hold_req_i;
        cnt <= sel_n_i ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
        rdy_q <= !sel_n_i && (rdy_q || cnt >= {1'b0, stall_i}); // kept high until select rises
        if (!wr_n_i) mem[addr_i[3:0]] <= wdata_i;
        if (!rd_n_i) a_q <= addr_i[3:0];
        keep <= !rd_n_i ? 2'h2 : (keep == 2'h0 ? 2'h0 : keep - 2'h1);
        // released bus inverts its value on every falling edge, so a stale value does not stay on it
        rd_q <= !rd_n_i ? mem[addr_i[3:0]] : (keep != 2'h0 ? mem[a_q] : ~rd_q);
    end
endmodule // ehw_mem_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb
    import ehw_pkg::*;
;
    logic clk_i, tim_clk, rst_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o, hold_req;
    logic [ADDR_W-1:0] req_addr_i, ext_address_bus_o;
    logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, ext_data_bus_o, mdata, exp_mem [16];
    logic [1:0] req_zone_i, stall;
    logic [LEAD_W-1:0] lead;
    logic [ACT_W-1:0] act;
    logic [TRAIL_W-1:0] trail;
    logic rdy_en, rdy_async, x2, half, hm_wr, hm_wdata, hold_mode_o, hold_granted_o, bclk, req_n, ack_n;
    logic ready, addr_oe, data_oe, wr_n, rd_n, dir, za, zb, zc, ctl_oe;
    int n_errors = 0, checks_done = 0, rsp_cnt = 0;

    ehw_core DUT (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_zone_i(req_zone_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .write_lead_cycles_i(lead),
        .write_active_cycles_i(act), .write_trail_cycles_i(trail), .ready_sampling_enable_i(rdy_en),
        .ready_async_select_i(rdy_async), .timing_doubling_select_i(x2), .bus_clock_half_i(half),
        .hold_mode_wr_i(hm_wr), .hold_mode_wdata_i(hm_wdata), .hold_mode_o(hold_mode_o),
        .hold_granted_o(hold_granted_o), .interface_timing_clock_i(tim_clk), .bus_clock_output_o(bclk),
        .bus_request_n_i(req_n), .bus_grant_ack_n_o(ack_n), .external_ready_in_i(ready),
        .ext_address_bus_o(ext_address_bus_o), .ext_address_bus_oe_o(addr_oe), .ext_data_bus_o(ext_data_bus_o),
        .ext_data_bus_oe_o(data_oe), .ext_data_bus_i(mdata), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
        .read_write_direction_o(dir), .zone_select_a_n_o(za), .zone_select_b_n_o(zb), .zone_select_c_n_o(zc),
        .control_oe_o(ctl_oe));

    ehw_mem_model u_mem (.tim_clk_i(tim_clk), .hold_req_i(hold_req), .stall_i(stall),
        .sel_n_i((za & zb & zc) | ~ctl_oe), .wr_n_i(wr_n | ~ctl_oe), .rd_n_i(rd_n | ~ctl_oe),
        .addr_i(ext_address_bus_o), .wdata_i(data_oe ? ext_data_bus_o : mdata),
        .bus_request_n_o(req_n), .ready_o(ready), .rdata_o(mdata));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        tim_clk = 1'b0;
        #3;
        forever #16 tim_clk = ~tim_clk;
    end
    // sampled half a period away from the edges that launch these outputs
    always @(negedge clk_i) if (rsp_valid_o === 1'b1) rsp_cnt++;
    always @(negedge tim_clk) if (!rst_i && ack_n === 1'b0) check("float_on_grant", {addr_oe, data_oe, ctl_oe}, 0);

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic access(input logic w, input logic [18:0] a, input logic [15:0] d, input logic [1:0] z,
                          output logic [15:0] rd);
        int n;
        n = 0;
        do @(negedge clk_i); while (req_ready_o !== 1'b1);
        {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_zone_i} = {1'b1, w, a, d, z};
        @(negedge clk_i);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        check("rsp_seen", rsp_valid_o, 1);
        rd = rsp_rdata_o;
    endtask

    task automatic set_hold(input logic v);
        @(negedge clk_i);
        {hm_wr, hm_wdata} = {1'b1, v};
        @(negedge clk_i);
        hm_wr = 1'b0;
    endtask

    task automatic hold_test(input logic h);
        int nf, na, t, tg, c0;
        logic lb;
        logic [15:0] rd;
        @(negedge clk_i);
        half = h;
        repeat (4) @(posedge tim_clk);
        hold_req = 1'b1;
        @(negedge req_n);
        {nf, na} = {32'd99, 32'd99};
        for (t = 1; t <= 10; t++) begin
            @(posedge tim_clk); #1;
            if (addr_oe === 1'b0 && nf == 99) nf = t;
            if (ack_n === 1'b0 && na == 99) na = t;
        end
        check("float_delay", nf <= (h ? 6 : 4), 1);
        check("ack_low_delay", na <= (h ? 8 : 5), 1);
        check("granted_flag", hold_granted_o, 1);
        c0 = rsp_cnt;
        fork access(1'b1, 19'h0_0005, 16'hA5C3, 2'h1, rd); join_none
        {tg, lb} = {32'd0, bclk};
        repeat (12) begin
            @(posedge tim_clk); #1;
            if (bclk !== lb) tg++;
            lb = bclk;
        end
        check("bus_clock_runs", tg > 0, h);
        check("stall_granted", rsp_cnt, c0);
        hold_req = 1'b0;
        @(posedge req_n);
        {nf, na} = {32'd99, 32'd99};
        for (t = 1; t <= 10; t++) begin
            @(posedge tim_clk); #1;
            if (addr_oe === 1'b1 && nf == 99) nf = t;
            if (ack_n === 1'b1 && na == 99) na = t;
        end
        check("ack_high_delay", na <= (h ? 4 : 3), 1);
        check("valid_delay", nf <= (h ? 6 : 4), 1);
        wait fork;
        exp_mem[5] = 16'hA5C3;
    endtask

    initial begin
        logic [15:0] rd, d;
        logic [18:0] a;
        logic [1:0] z;
        logic w;
        void'($urandom(41567));
        {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_zone_i} = '0;
        {lead, act, trail, rdy_en, rdy_async, x2, half, hm_wr, hm_wdata, stall} = '0;
        foreach (exp_mem[i]) exp_mem[i] = 16'h0000;
        rst_i = 1'b1;
        hold_req = 1'b1;
        // longer than 8 cycles: reset must also reach the timing domain
        repeat (20) @(negedge clk_i);
        check("ack_in_reset", ack_n, 0);
        check("oe_in_reset", {addr_oe, data_oe, ctl_oe}, 0);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("hold_mode_rst", hold_mode_o, 0);
        hold_req = 1'b0;
        repeat (10) @(posedge tim_clk);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_i);
            {lead, act, trail, rdy_en, rdy_async, x2, half, stall} = 13'($urandom);
            {a, d, z, w} = {19'($urandom), 16'($urandom), 2'($urandom_range(0, 2)), 1'(i < 8 || $urandom % 2)};
            access(w, a, d, z, rd);
            if (w) exp_mem[a[3:0]] = d;
            else check("read_data", rd, exp_mem[a[3:0]]);
            repeat (3) @(posedge tim_clk); #1;
            check("addr_held", ext_address_bus_o, a);
        end
        hold_test(1'b0);
        hold_test(1'b1);
        hold_req = 1'b1;
        repeat (10) @(posedge tim_clk);
        set_hold(1'b1);
        repeat (4) @(posedge tim_clk); #1;
        check("ack_forced_high", ack_n, 1);
        check("bus_driven", {addr_oe, ctl_oe}, 3);
        check("hold_mode_set", hold_mode_o, 1);
        access(1'b0, 19'h0_0005, 16'h0000, 2'h2, rd);
        check("read_in_hold_mode", rd, exp_mem[5]);
        set_hold(1'b0);
        hold_req = 1'b0;
        repeat (10) @(posedge tim_clk);
        conclude();
    end

    initial begin
        #200_000;
        n_errors++;
        conclude();
    end
endmodule // tb
